// File: ufc_channel.v
// ufc_channel: one serial channel with fifos, hardware and software flow control
// assumes: apb master on pclk; serial_in and cts_n are asynchronous pins
`include "ufc_defines.vh"
`default_nettype none
module ufc_channel (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire serial_in,
  input wire cts_n,
  output reg serial_out,
  output reg rts_n,
  output reg irq,
  output reg rx_dma_request_n,
  output reg tx_dma_request_n
);
  // one-hot states of both shifters
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_START = 4'b0010;
  localparam [3:0] ST_DATA = 4'b0100;
  localparam [3:0] ST_STOP = 4'b1000;
  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  reg [7:0] interrupt_enable_reg, fifo_control_reg, lcr, modem_control_reg, enhanced_feature_reg, flow_threshold_reg, trigger_level_reg; // software control
  reg [7:0] xon1, xon2, xoff1, xoff2; // flow characters
  reg [15:0] div; // baud divisor
  reg [1:0] sync1, sync2; // {cts_n, serial_in} synchronisers
  reg xoff_int; // iir bit 4 source
  reg xoff_hold; // remote asked us to stop
  reg rts_on; // auto rts state
  reg [15:0] bd_cnt;
  reg tick; // 16x oversample enable
  reg [3:0] rx_st, tx_st;
  reg [3:0] rx_tk, tx_tk;
  reg [2:0] rx_bc, tx_bc;
  reg [7:0] rx_sh, tx_sh;
  reg rx_done; // one-cycle pulse per received char
  reg [7:0] rx_byte;
  reg [2:0] rx_err; // {break, framing, parity}
  reg hold_v; // char waiting for re-evaluation
  reg [7:0] hold_d;
  reg [2:0] hold_e;
  reg pend_v; // first of a pair seen
  reg pend_off; // pending pair is xoff
  reg [7:0] pend_d;
  reg rx_push;
  reg [10:0] rx_pdata;
  reg xoff_sent; // we have sent xoff to remote
  reg seq; // second char of a pair pending
  reg [1:0] sent_mode; // tx mode in force when xoff went out
  reg [31:0] rd_mux;
  reg rd_hit;
  reg [6:0] rx_trig, tx_trig;
  // ------------------------------------------------------------
  // apb access
  // ------------------------------------------------------------
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire rxd = sync2[0];
  wire cts_s = sync2[1];
  wire [6:0] cap = fifo_control_reg[`UFC_FCR_EN] ? `UFC_DEPTH : `UFC_DEPTH_OFF;
  wire [6:0] rx_count, tx_count;
  wire [10:0] rx_head;
  wire [7:0] tx_head;
  wire rx_full, rx_empty, tx_full, tx_empty;
  wire tx_push = wr & (paddr == `UFC_OFF_DATA);
  wire rx_pop = rd & (paddr == `UFC_OFF_DATA);
  reg tx_pop;
  // fifos: rx carries 8 data bits plus 3 error bits
  ufc_fifo #(.W(11)) u_rx_fifo (
    .pclk(pclk), .presetn(presetn), .push(rx_push), .push_data(rx_pdata),
    .pop(rx_pop), .cap(cap), .head(rx_head), .count(rx_count),
    .full(rx_full), .empty(rx_empty));
  ufc_fifo #(.W(8)) u_tx_fifo (
    .pclk(pclk), .presetn(presetn), .push(tx_push), .push_data(pwdata[7:0]),
    .pop(tx_pop), .cap(cap), .head(tx_head), .count(tx_count),
    .full(tx_full), .empty(tx_empty));
  // read mux and decode; unmapped addresses answer with pslverr
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == `UFC_OFF_DATA) begin
      rd_mux[10:0] = rx_head;
    end else if (paddr == `UFC_OFF_IER) begin
      rd_mux[7:0] = interrupt_enable_reg;
    end else if (paddr == `UFC_OFF_IIR) begin
      rd_mux[7:0] = xoff_int ? `UFC_IIR_XOFF : `UFC_IIR_NONE;
    end else if (paddr == `UFC_OFF_FCR) begin
      rd_mux[7:0] = fifo_control_reg;
    end else if (paddr == `UFC_OFF_LCR) begin
      rd_mux[7:0] = lcr;
    end else if (paddr == `UFC_OFF_MCR) begin
      rd_mux[7:0] = modem_control_reg;
    end else if (paddr == `UFC_OFF_EFR) begin
      rd_mux[7:0] = enhanced_feature_reg;
    end else if (paddr == `UFC_OFF_TCR) begin
      rd_mux[7:0] = flow_threshold_reg;
    end else if (paddr == `UFC_OFF_TLR) begin
      rd_mux[7:0] = trigger_level_reg;
    end else if (paddr == `UFC_OFF_DIV) begin
      rd_mux[15:0] = div;
    end else if (paddr == `UFC_OFF_XON1) begin
      rd_mux[7:0] = xon1;
    end else if (paddr == `UFC_OFF_XON2) begin
      rd_mux[7:0] = xon2;
    end else if (paddr == `UFC_OFF_XOFF1) begin
      rd_mux[7:0] = xoff1;
    end else if (paddr == `UFC_OFF_XOFF2) begin
      rd_mux[7:0] = xoff2;
    end else if (paddr == `UFC_OFF_STAT) begin
      rd_mux[19:0] = {~cts_s, rts_on, xoff_sent, xoff_hold, 1'b0, tx_count,
                      1'b0, rx_count};
    end else begin
      rd_hit = 1'b0;
    end
  end
  // no wait state: answer is latched in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~rd_hit;
      end
    end
  end
  // software writable registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_reg <= `UFC_RST_REG;
      fifo_control_reg <= `UFC_RST_REG;
      lcr <= `UFC_RST_REG;
      modem_control_reg <= `UFC_RST_REG;
      enhanced_feature_reg <= `UFC_RST_REG;
      flow_threshold_reg <= `UFC_RST_REG;
      trigger_level_reg <= `UFC_RST_REG;
      div <= `UFC_RST_DIV;
      xon1 <= `UFC_RST_REG;
      xon2 <= `UFC_RST_REG;
      xoff1 <= `UFC_RST_REG;
      xoff2 <= `UFC_RST_REG;
    end else if (wr) begin
      if (paddr == `UFC_OFF_IER) begin
        interrupt_enable_reg <= pwdata[7:0];
      end else if (paddr == `UFC_OFF_FCR) begin
        fifo_control_reg <= pwdata[7:0];
      end else if (paddr == `UFC_OFF_LCR) begin
        lcr <= pwdata[7:0];
      end else if (paddr == `UFC_OFF_MCR) begin
        modem_control_reg <= pwdata[7:0];
      end else if (paddr == `UFC_OFF_EFR) begin
        enhanced_feature_reg <= pwdata[7:0];
      end else if (paddr == `UFC_OFF_TCR) begin
        flow_threshold_reg <= pwdata[7:0];
      end else if (paddr == `UFC_OFF_TLR) begin
        trigger_level_reg <= pwdata[7:0];
      end else if (paddr == `UFC_OFF_DIV) begin
        div <= pwdata[15:0];
      end else if (paddr == `UFC_OFF_XON1) begin
        xon1 <= pwdata[7:0];
      end else if (paddr == `UFC_OFF_XON2) begin
        xon2 <= pwdata[7:0];
      end else if (paddr == `UFC_OFF_XOFF1) begin
        xoff1 <= pwdata[7:0];
      end else if (paddr == `UFC_OFF_XOFF2) begin
        xoff2 <= pwdata[7:0];
      end
    end
  end
  // ------------------------------------------------------------
  // pin synchronisers and baud divider
  // ------------------------------------------------------------
  // divisor 0 behaves as 1 so the tick never stops
  wire [15:0] div_eff = (div == 16'h0000) ? 16'h0001 : div;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 2'b11;
      sync2 <= 2'b11;
      bd_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      sync1 <= {cts_n, serial_in};
      sync2 <= sync1;
      if (bd_cnt >= div_eff - 16'h0001) begin
        bd_cnt <= 16'h0000;
        tick <= 1'b1;
      end else begin
        bd_cnt <= bd_cnt + 16'h0001;
        tick <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------
  // trigger levels and dma requests
  // ------------------------------------------------------------
  // a nonzero tlr nibble overrides the fixed fcr choice, in steps of 4
  always @* begin
    if (!fifo_control_reg[`UFC_FCR_EN]) begin
      rx_trig = `UFC_DEPTH_OFF;
      tx_trig = `UFC_DEPTH_OFF;
    end else begin
      case (fifo_control_reg[7:6])
        2'b00: rx_trig = `UFC_RX_TRIG0;
        2'b01: rx_trig = `UFC_RX_TRIG1;
        2'b10: rx_trig = `UFC_RX_TRIG2;
        default: rx_trig = `UFC_RX_TRIG3;
      endcase
      case (fifo_control_reg[5:4])
        2'b00: tx_trig = `UFC_TX_TRIG0;
        2'b01: tx_trig = `UFC_TX_TRIG1;
        2'b10: tx_trig = `UFC_TX_TRIG2;
        default: tx_trig = `UFC_TX_TRIG3;
      endcase
      if (trigger_level_reg[7:4] != 4'h0) begin
        rx_trig = {1'b0, trigger_level_reg[7:4], 2'b00};
      end
      if (trigger_level_reg[3:0] != 4'h0) begin
        tx_trig = {1'b0, trigger_level_reg[3:0], 2'b00};
      end
    end
  end
  wire [6:0] halt_lvl = {1'b0, flow_threshold_reg[3:0], 2'b00};
  wire [6:0] resume_lvl = {1'b0, flow_threshold_reg[7:4], 2'b00};
  // rts, irq and dma pins, all straight from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_on <= 1'b1;
      rts_n <= 1'b1;
      irq <= 1'b0;
      rx_dma_request_n <= 1'b1;
      tx_dma_request_n <= 1'b0;
    end else begin
      if (rx_count >= halt_lvl) begin
        rts_on <= 1'b0;
      end else if (rx_count <= resume_lvl) begin
        rts_on <= 1'b1;
      end
      rts_n <= enhanced_feature_reg[`UFC_EFR_AUTO_RTS] ? ~rts_on : ~modem_control_reg[`UFC_MCR_RTS];
      irq <= xoff_int & interrupt_enable_reg[`UFC_IER_XOFF];
      rx_dma_request_n <= ~(rx_count >= rx_trig);
      tx_dma_request_n <= ~((cap - tx_count) >= tx_trig);
    end
  end
  // ------------------------------------------------------------
  // receiver shifter: mid-bit sampling, break and framing checks
  // ------------------------------------------------------------
  wire [2:0] last_bit = `UFC_BITS_MIN_LAST + {1'b0, lcr[1:0]};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st <= ST_IDLE;
      rx_tk <= 4'h0;
      rx_bc <= 3'h0;
      rx_sh <= 8'h00;
      rx_done <= 1'b0;
      rx_byte <= 8'h00;
      rx_err <= 3'h0;
    end else begin
      rx_done <= 1'b0;
      if (tick) begin
        rx_tk <= rx_tk + 4'h1;
        case (rx_st)
          ST_IDLE: begin
            rx_tk <= 4'h0;
            if (!rxd) begin
              rx_st <= ST_START;
            end
          end
          ST_START: begin
            if (rx_tk == `UFC_OSR_MID) begin
              rx_tk <= 4'h0;
              rx_bc <= 3'h0;
              rx_st <= rxd ? ST_IDLE : ST_DATA; // false start is dropped
            end
          end
          ST_DATA: begin
            if (rx_tk == `UFC_OSR_LAST) begin
              rx_sh <= {rxd, rx_sh[7:1]};
              rx_bc <= rx_bc + 3'h1;
              if (rx_bc == last_bit) begin
                rx_st <= ST_STOP;
              end
            end
          end
          default: begin
            if (rx_tk == `UFC_OSR_LAST) begin
              rx_st <= ST_IDLE;
              rx_done <= 1'b1;
              rx_byte <= rx_sh >> (2'h3 - lcr[1:0]); // short words sit low
              rx_err <= {~rxd & (rx_sh == 8'h00), ~rxd, 1'b0};
            end
          end
        endcase
      end
    end
  end
  // ------------------------------------------------------------
  // receive flow character detection
  // ------------------------------------------------------------
  wire ev_v = rx_done | hold_v;
  wire [7:0] ev_d = rx_done ? rx_byte : hold_d;
  wire [2:0] ev_e = rx_done ? rx_err : hold_e;
  wire [1:0] rxm = enhanced_feature_reg[1:0];
  wire ev_ok = (ev_e == 3'h0) & (rxm != 2'b00);
  wire m_off = (rxm == 2'b01) ? (ev_d == xoff2) : (ev_d == xoff1);
  wire m_on = (rxm == 2'b01) ? (ev_d == xon2) : (ev_d == xon1);
  wire iir_rd = rd & (paddr == `UFC_OFF_IIR) & prdata[4];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_v <= 1'b0;
      hold_d <= 8'h00;
      hold_e <= 3'h0;
      pend_v <= 1'b0;
      pend_off <= 1'b0;
      pend_d <= 8'h00;
      rx_push <= 1'b0;
      rx_pdata <= 11'h000;
      xoff_hold <= 1'b0;
      xoff_int <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      hold_v <= 1'b0;
      if (iir_rd) begin
        xoff_int <= 1'b0;
      end
      if (ev_v) begin
        if (rxm == 2'b11 && pend_v) begin
          pend_v <= 1'b0;
          if (ev_ok && ev_d == (pend_off ? xoff2 : xon2)) begin
            xoff_hold <= pend_off;
            xoff_int <= pend_off & interrupt_enable_reg[`UFC_IER_XOFF];
          end else begin
            rx_push <= 1'b1;
            rx_pdata <= {3'h0, pend_d};
            hold_v <= 1'b1; // judge this char again next cycle
            hold_d <= ev_d;
            hold_e <= ev_e;
          end
        end else if (rxm == 2'b11 && ev_ok && (ev_d == xoff1 || ev_d == xon1)) begin
          pend_v <= 1'b1;
          pend_off <= (ev_d == xoff1);
          pend_d <= ev_d;
        end else if (rxm != 2'b11 && ev_ok && m_off) begin
          xoff_hold <= 1'b1;
          xoff_int <= interrupt_enable_reg[`UFC_IER_XOFF];
        end else if (rxm != 2'b11 && ev_ok && m_on) begin
          xoff_hold <= 1'b0;
          xoff_int <= 1'b0;
        end else begin
          rx_push <= 1'b1;
          rx_pdata <= {ev_e, ev_d};
          if (xoff_hold && modem_control_reg[`UFC_MCR_XON_ANY]) begin
            xoff_hold <= 1'b0;
            xoff_int <= 1'b0;
          end
          if (enhanced_feature_reg[`UFC_EFR_SPECIAL] && ev_e == 3'h0 && ev_d == xoff2) begin
            xoff_int <= 1'b1;
          end
        end
      end
    end
  end
  // ------------------------------------------------------------
  // transmit flow characters toward the remote
  // ------------------------------------------------------------
  wire [1:0] txm = enhanced_feature_reg[3:2];
  wire send_off = (txm != 2'b00) & ~xoff_sent & (rx_count > halt_lvl);
  wire send_on = xoff_sent & ((rx_count <= resume_lvl) | (txm != sent_mode));
  wire fl_req = seq | send_off | send_on;
  wire [1:0] md = (xoff_sent | seq) ? sent_mode : txm;
  wire use2 = (md == 2'b01) | seq;
  wire [7:0] fl_char = xoff_sent ? (use2 ? xon2 : xon1) : (use2 ? xoff2 : xoff1);
  wire cts_ok = ~enhanced_feature_reg[`UFC_EFR_AUTO_CTS] | ~cts_s;
  wire fl_go = tick & (tx_st == ST_IDLE) & cts_ok & fl_req;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xoff_sent <= 1'b0;
      seq <= 1'b0;
      sent_mode <= 2'b00;
    end else if (fl_go) begin
      if (!xoff_sent && !seq) begin
        sent_mode <= txm;
      end
      if (md == 2'b11 && !seq) begin
        seq <= 1'b1; // pair: second char follows
      end else begin
        seq <= 1'b0;
        xoff_sent <= ~xoff_sent;
      end
    end
  end
  // ------------------------------------------------------------
  // transmitter shifter; cts checked only between bytes
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st <= ST_IDLE;
      tx_tk <= 4'h0;
      tx_bc <= 3'h0;
      tx_sh <= 8'h00;
      tx_pop <= 1'b0;
      serial_out <= 1'b1;
    end else begin
      tx_pop <= 1'b0;
      if (tick) begin
        tx_tk <= tx_tk + 4'h1;
        case (tx_st)
          ST_IDLE: begin
            tx_tk <= 4'h0;
            serial_out <= 1'b1;
            if (cts_ok && fl_req) begin
              tx_sh <= fl_char;
              serial_out <= 1'b0;
              tx_st <= ST_START;
            end else if (cts_ok && !tx_empty && !xoff_hold) begin
              tx_sh <= tx_head;
              tx_pop <= 1'b1;
              serial_out <= 1'b0;
              tx_st <= ST_START;
            end
          end
          ST_START: begin
            if (tx_tk == `UFC_OSR_LAST) begin
              tx_bc <= 3'h0;
              serial_out <= tx_sh[0];
              tx_sh <= {1'b0, tx_sh[7:1]};
              tx_st <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (tx_tk == `UFC_OSR_LAST) begin
              tx_bc <= tx_bc + 3'h1;
              if (tx_bc == last_bit) begin
                serial_out <= 1'b1;
                tx_st <= ST_STOP;
              end else begin
                serial_out <= tx_sh[0];
                tx_sh <= {1'b0, tx_sh[7:1]};
              end
            end
          end
          default: begin
            if (tx_tk == `UFC_OSR_LAST) begin
              tx_st <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule // ufc_channel
`default_nettype wire

// File: ufc_defines.vh
// constants for the serial channel flow control block
// assumes: included by bare name from each design file
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH
// ------------------------------------------------------------
// register byte offsets on the apb bus
// ------------------------------------------------------------
`define UFC_OFF_DATA 8'h00
`define UFC_OFF_IER 8'h04
`define UFC_OFF_IIR 8'h08
`define UFC_OFF_FCR 8'h0C
`define UFC_OFF_LCR 8'h10
`define UFC_OFF_MCR 8'h14
`define UFC_OFF_EFR 8'h18
`define UFC_OFF_TCR 8'h1C
`define UFC_OFF_TLR 8'h20
`define UFC_OFF_DIV 8'h24
`define UFC_OFF_XON1 8'h28
`define UFC_OFF_XON2 8'h2C
`define UFC_OFF_XOFF1 8'h30
`define UFC_OFF_XOFF2 8'h34
`define UFC_OFF_STAT 8'h38
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define UFC_EFR_AUTO_CTS 7
`define UFC_EFR_AUTO_RTS 6
`define UFC_EFR_SPECIAL 5
`define UFC_MCR_RTS 1
`define UFC_MCR_XON_ANY 5
`define UFC_IER_XOFF 5
`define UFC_FCR_EN 0
// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define UFC_RST_REG 8'h00
`define UFC_RST_DIV 16'h0001
`define UFC_IIR_NONE 8'h01
`define UFC_IIR_XOFF 8'h10
// ------------------------------------------------------------
// sizes and timing counts
// ------------------------------------------------------------
`define UFC_DEPTH 7'h40
`define UFC_DEPTH_OFF 7'h01
`define UFC_OSR_LAST 4'hF
`define UFC_OSR_MID 4'h7
`define UFC_BITS_MIN_LAST 3'h4
`define UFC_RX_TRIG0 7'h08
`define UFC_RX_TRIG1 7'h10
`define UFC_RX_TRIG2 7'h38
`define UFC_RX_TRIG3 7'h3C
`define UFC_TX_TRIG0 7'h08
`define UFC_TX_TRIG1 7'h10
`define UFC_TX_TRIG2 7'h20
`define UFC_TX_TRIG3 7'h38
`endif

// File: ufc_fifo.v
// ufc_fifo: 64-entry first-word-fall-through buffer with a capacity limit
// assumes: one clock, push and pop from logic on that clock
`include "ufc_defines.vh"
`default_nettype none
module ufc_fifo #(
  parameter W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire push,
  input wire [W-1:0] push_data,
  input wire pop,
  input wire [6:0] cap,
  output wire [W-1:0] head,
  output wire [6:0] count,
  output wire full,
  output wire empty
);
  reg [W-1:0] mem [0:63]; // storage, not reset
  reg [5:0] wr_ptr; // wraps naturally at 64
  reg [5:0] rd_ptr;
  reg [6:0] cnt;
  wire do_push;
  wire do_pop;
  // cap shrinks the buffer to one entry while fifo mode is off
  assign full = (cnt >= cap);
  assign empty = (cnt == 7'h00);
  assign do_push = push & ~full; // overflow drops the byte
  assign do_pop = pop & ~empty;
  assign head = mem[rd_ptr];
  assign count = cnt;
  // ------------------------------------------------------------
  // pointers and level
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
      cnt <= 7'h00;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 6'h01;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 6'h01;
      end
      if (do_push & ~do_pop) begin
        cnt <= cnt + 7'h01;
      end else if (do_pop & ~do_push) begin
        cnt <= cnt - 7'h01;
      end
    end
  end
  // data array write
  always @(posedge pclk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end
endmodule // ufc_fifo
`default_nettype wire

// File: ufc_monitor.sv
// ufc_monitor: port checks on one serial channel
// assumes: bound to ufc_channel, divisor left at one
`default_nettype none
module ufc_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------
  // apb and line checks
  // --------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // two-step transfer, and an iir read that saw the xoff flag
  sequence setup_s; psel && !penable ##1 psel && penable; endsequence
  sequence iir_hit_s; pready && !pwrite && paddr == 8'h08 && prdata[4]; endsequence
  apb_answer_a: assert property (setup_s |-> pready) else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  ready_cause_a: assert property (pready |-> psel && penable) else $error("stray ready");
  rdata_hold_a: assert property (!psel |=> $stable(prdata)) else $error("rdata moved");
  addr_map_a: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h38))
    else $error("bad slave error");
  err_time_a: assert property ($rose(pslverr) |-> pready) else $error("stray slave error");
  start_bit_a: assert property ($fell(serial_out) |-> !serial_out [*8])
    else $error("low bit too short");
  bit_time_a: assert property ($changed(serial_out) |=> $stable(serial_out) [*8])
    else $error("bit too short");
  irq_clear_a: assert property (iir_hit_s |-> ##[1:2] !irq)
    else $error("irq kept after read");
endmodule // ufc_monitor
bind ufc_channel ufc_monitor ufc_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_out(serial_out), .irq(irq));
`default_nettype wire

// File: ufc_peer.sv
// ufc_peer: remote sender, 8 data bits, one stop, 16 clocks a bit
// assumes: bench drives stop to hold off the channel
`default_nettype none
module ufc_peer (
  input wire logic pclk,
  input wire logic stop,
  output var logic serial_in,
  output wire logic cts_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------
  // line and handshake
  // --------------------
  // line rests high between frames
  initial serial_in = 1'b1;
  assign cts_n = stop;
  // this sender never looks at rts_n; every byte it begins runs to its stop bit
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      serial_in <= i == 0 ? 1'b0 : i == 9 ? 1'b1 : b[i - 1];
      repeat (16) @(posedge pclk);
    end
  endtask
endmodule // ufc_peer
`default_nettype wire

// File: uart_flow_control_tb.sv
// uart_flow_control_tb: self-checking bench for one serial channel
// assumes: ufc_peer on the line, divisor kept at one
`default_nettype none
module uart_flow_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------
  // signals and tasks
  // --------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic serial_in, cts_n, serial_out, rts_n, irq, rxd_n, txd_n, stop;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  // address, write value, read-back value; unmapped last
  logic [23:0] rows [8] = '{24'h04_2020, 24'h0C_0101, 24'h10_0303, 24'h1C_1212,
    24'h34_1313, 24'h18_2020, 24'h08_FF01, 24'h3C_5500};
  ufc_channel ufc_channel_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in(serial_in), .cts_n(cts_n), .serial_out(serial_out),
    .rts_n(rts_n), .irq(irq), .rx_dma_request_n(rxd_n), .tx_dma_request_n(txd_n));
  ufc_peer ufc_peer_i (.pclk(pclk), .stop(stop), .serial_in(serial_in), .cts_n(cts_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one transfer; a hang is cut by the cycle ceiling
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // the whole run needs about 2000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, stop} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    chk({27'h0, serial_out, rts_n, irq, rxd_n, txd_n}, 32'h0000_001A);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i][23:16], rows[i][15:8]);
      apb(1'b0, rows[i][23:16], 8'h00);
      chk({rd[30:0], er}, {23'h0, rows[i][7:0], rows[i][23:16] == 8'h3C});
    end
    // special character: flagged, stored, cleared by an iir read
    ufc_peer_i.send(8'h13);
    while (irq !== 1'b1) @(posedge pclk);
    apb(1'b0, 8'h00, 8'h00);
    chk(rd, 32'h0000_0013);
    apb(1'b0, 8'h08, 8'h00);
    chk(rd, 32'h0000_0010);
    apb(1'b0, 8'h08, 8'h00);
    chk({rd[30:0], irq}, 32'h0000_0002);
    // auto rts: past halt 8 with one extra byte, then down to resume 4
    apb(1'b1, 8'h18, 8'h40);
    for (int i = 0; i < 9; i++) begin
      ufc_peer_i.send(i[7:0]);
      apb(1'b0, 8'h38, 8'h00);
      chk({24'h0, rts_n, rd[6:0]}, {24'h0, i > 6, 7'(i + 1)});
      chk({30'h0, rxd_n, txd_n}, {30'h0, i < 7, 1'b0});
    end
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'h00, 8'h00);
      chk(rd, 32'(i));
      apb(1'b0, 8'h38, 8'h00);
      chk({24'h0, rts_n, rd[6:0]}, {24'h0, i < 4, 7'(8 - i)});
    end
    // auto cts: blocked queue stays put, a late drop lets one byte finish
    stop <= 1'b1;
    apb(1'b1, 8'h18, 8'h80);
    apb(1'b1, 8'h00, 8'h5A);
    apb(1'b1, 8'h00, 8'hA5);
    repeat (40) @(posedge pclk);
    chk({31'h0, serial_out}, 32'h1);
    stop <= 1'b0;
    while (serial_out !== 1'b0) @(posedge pclk);
    stop <= 1'b1;
    repeat (200) @(posedge pclk);
    apb(1'b0, 8'h38, 8'h00);
    chk({23'h0, rd[15:8], serial_out}, 32'h0000_0003);
    summarize();
  end
endmodule // uart_flow_control_tb
`default_nettype wire
